//--- verilog/sfrb_bank.sv
`timescale 1ns/1ps
`include "sfrb_defs.svh"
// Behaviour
// - system enable bank at 00h, cleared by power-up clear
// - watchdog enable ignored in reset mode
// - watchdog enable gates only interval mode
// - enables gate oscillator, pin, flash events
// - serial enable bank at 01h, cleared
// - system flag bank at 02h, bits 0-4
// - watchdog flag set on reset-mode overflow or key
// - watchdog flag cleared on power-on or pin reset
// - oscillator flag set on fault, reset one
// - external reset flag set by pin reset
// - power-on flag forced one by power-on
// - pin flag set by pin event, cleared
// - serial flag bank at 03h, tx reset one
// - plain reset bits reload on power-up clear
// - parenthesised bits reload on power-on only
// - unassigned bit positions hold no storage
// - enable bits block conditionally maskable sources
module sfrb_bank (
    input  wire logic                     clk,              // system clock, 250 MHz
    input  wire logic                     rst_n,            // power-on reset, sync, low
    input  wire logic                     powerUpClear,     // power-up clear pulse/level
    input  wire sfrb_pkg::sfrb_addr_t     busAddr,          // byte address
    input  wire logic                     busWrite,         // write strobe
    input  wire logic                     busRead,          // read strobe
    input  wire sfrb_pkg::sfrb_byte_t     busWdata,         // write data
    output sfrb_pkg::sfrb_byte_t          busRdata,         // read data, registered
    input  wire sfrb_pkg::sfrb_wdog_mode_t wdogMode,        // watchdog mode
    input  wire logic                     wdogOverflow,     // watchdog overflow pulse
    input  wire logic                     wdogKeyViolation, // watchdog key violation pulse
    input  wire logic                     pinInterruptMode, // combined pin in interrupt mode
    input  wire logic                     pinEvent,         // combined pin event pulse
    input  wire logic                     pinResetEvent,    // pin reset condition pulse
    input  wire logic                     oscFault,         // oscillator fault level
    input  wire logic                     flashViolation,   // flash access violation level
    input  wire logic                     serialARxEvent,   // unit A receive event
    input  wire logic                     serialATxEvent,   // unit A transmit event
    input  wire logic                     serialBRxEvent,   // unit B receive event
    input  wire logic                     serialBTxEvent,   // unit B transmit event
    output logic                          wdogIrq,          // watchdog interrupt request
    output logic                          nmiIrq,           // conditionally maskable request
    output logic                          serialRxIrq,      // serial receive request
    output logic                          serialTxIrq       // serial transmit request
);
    import sfrb_pkg::*;

    logic       oscSync1, oscSync2, oscSync3;
    logic       oscFaultSeen;
    logic       wrEnSys;
    logic       wrEnSerial;
    logic       wrFlagSys;
    logic       wrFlagSerial;
    logic       pucClear;
    logic       porClear;
    // only the implemented bits get flip-flops
    logic       wdog_irq_en_reg;
    logic       osc_fault_irq_en_reg;
    logic       pin_event_irq_en_reg;
    logic       flash_violation_irq_en_reg;
    logic [3:0] serial_irq_en_reg;
    logic       wdogFlag;
    logic       oscFaultFlag;
    logic       powerOnFlag;
    logic       extResetFlag;
    logic       pinEventFlag;
    logic [3:0] serialFlag;
    logic [3:0] serialEvent;
    sfrb_byte_t enableSys;
    sfrb_byte_t enableSerial;
    sfrb_byte_t flagsSys;
    sfrb_byte_t flagsSerial;
    sfrb_byte_t rdataNext;

    // power-on also implies power-up clear
    assign pucClear = !rst_n || powerUpClear;
    assign porClear = !rst_n;

    // address decode
    always_comb begin
        wrEnSys      = 1'b0;
        wrEnSerial   = 1'b0;
        wrFlagSys    = 1'b0;
        wrFlagSerial = 1'b0;
        if (busWrite && busAddr == `SFRB_ADDR_ENABLE_SYS) begin
            wrEnSys = 1'b1;
        end else if (busWrite && busAddr == `SFRB_ADDR_ENABLE_SERIAL) begin
            wrEnSerial = 1'b1;
        end else if (busWrite && busAddr == `SFRB_ADDR_FLAGS_SYS) begin
            wrFlagSys = 1'b1;
        end else if (busWrite && busAddr == `SFRB_ADDR_FLAGS_SERIAL) begin
            wrFlagSerial = 1'b1;
        end
    end

    // oscillator fault is asynchronous to this clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oscSync1 <= 1'b0;
            oscSync2 <= 1'b0;
            oscSync3 <= 1'b0;
        end else begin
            oscSync1 <= oscFault;
            oscSync2 <= oscSync1;
            oscSync3 <= oscSync2;
        end
    end
    assign oscFaultSeen = oscSync2 && oscSync3;

    // system enable bank
    always_ff @(posedge clk) begin
        if (pucClear) begin
            wdog_irq_en_reg            <= `SFRB_RST_ENABLE;
            osc_fault_irq_en_reg       <= `SFRB_RST_ENABLE;
            pin_event_irq_en_reg       <= `SFRB_RST_ENABLE;
            flash_violation_irq_en_reg <= `SFRB_RST_ENABLE;
        end else if (wrEnSys) begin
            wdog_irq_en_reg            <= busWdata[`SFRB_BIT_WDOG_EN];
            osc_fault_irq_en_reg       <= busWdata[`SFRB_BIT_OSC_EN];
            pin_event_irq_en_reg       <= busWdata[`SFRB_BIT_PIN_EN];
            flash_violation_irq_en_reg <= busWdata[`SFRB_BIT_FLASH_EN];
        end
    end

    // serial enable bank
    always_ff @(posedge clk) begin
        if (pucClear) begin
            serial_irq_en_reg <= {4{`SFRB_RST_ENABLE}};
        end else if (wrEnSerial) begin
            serial_irq_en_reg <= busWdata[3:0];
        end
    end

    // watchdog flag: power-on reset or pin reset clears it
    sfrb_flag_bit #(.RESET_VALUE(`SFRB_RST_WDOG_FLAG)) uWdogFlag (
        .clk       (clk),
        // pin reset only counts while the pin is in reset mode
        .clear     (porClear || (pinResetEvent && !pinInterruptMode)),
        .setEvent  ((wdogOverflow && wdogMode == SFRB_WDOG_RESET)
                    || wdogKeyViolation),
        .writeEn   (wrFlagSys),
        .writeData (busWdata[`SFRB_BIT_WDOG_FLAG]),
        .flag      (wdogFlag)
    );

    sfrb_flag_bit #(.RESET_VALUE(`SFRB_RST_OSC_FLAG)) uOscFlag (
        .clk       (clk),
        .clear     (pucClear),
        .setEvent  (oscFaultSeen),
        .writeEn   (wrFlagSys),
        .writeData (busWdata[`SFRB_BIT_OSC_FLAG]),
        .flag      (oscFaultFlag)
    );

    // no set source besides power-on itself
    sfrb_flag_bit #(.RESET_VALUE(`SFRB_RST_PON_FLAG)) uPonFlag (
        .clk       (clk),
        .clear     (porClear),
        .setEvent  (1'b0),
        .writeEn   (wrFlagSys),
        .writeData (busWdata[`SFRB_BIT_PON_FLAG]),
        .flag      (powerOnFlag)
    );

    sfrb_flag_bit #(.RESET_VALUE(`SFRB_RST_EXT_FLAG)) uExtFlag (
        .clk       (clk),
        .clear     (porClear),
        .setEvent  (pinResetEvent && !pinInterruptMode),
        .writeEn   (wrFlagSys),
        .writeData (busWdata[`SFRB_BIT_EXT_FLAG]),
        .flag      (extResetFlag)
    );

    sfrb_flag_bit #(.RESET_VALUE(`SFRB_RST_PIN_FLAG)) uPinFlag (
        .clk       (clk),
        .clear     (pucClear),
        .setEvent  (pinEvent && pinInterruptMode),
        .writeEn   (wrFlagSys),
        .writeData (busWdata[`SFRB_BIT_PIN_FLAG]),
        .flag      (pinEventFlag)
    );

    assign serialEvent = {serialBTxEvent, serialBRxEvent, serialATxEvent, serialARxEvent};

    // tx flags come up set: an idle transmitter is ready
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : gSerial
            sfrb_flag_bit #(
                .RESET_VALUE((gi % 2 == 1) ? `SFRB_RST_TX_FLAG : `SFRB_RST_RX_FLAG)
            ) uSerialFlag (
                .clk       (clk),
                .clear     (pucClear),
                .setEvent  (serialEvent[gi]),
                .writeEn   (wrFlagSerial),
                .writeData (busWdata[gi]),
                .flag      (serialFlag[gi])
            );
        end
    endgenerate

    // unassigned positions are constant zero
    always_comb begin
        enableSys    = 8'h00;
        enableSys[`SFRB_BIT_WDOG_EN]  = wdog_irq_en_reg;
        enableSys[`SFRB_BIT_OSC_EN]   = osc_fault_irq_en_reg;
        enableSys[`SFRB_BIT_PIN_EN]   = pin_event_irq_en_reg;
        enableSys[`SFRB_BIT_FLASH_EN] = flash_violation_irq_en_reg;
        enableSerial = {4'h0, serial_irq_en_reg};
        flagsSys     = 8'h00;
        flagsSys[`SFRB_BIT_WDOG_FLAG] = wdogFlag;
        flagsSys[`SFRB_BIT_OSC_FLAG]  = oscFaultFlag;
        flagsSys[`SFRB_BIT_PON_FLAG]  = powerOnFlag;
        flagsSys[`SFRB_BIT_EXT_FLAG]  = extResetFlag;
        flagsSys[`SFRB_BIT_PIN_FLAG]  = pinEventFlag;
        flagsSerial  = {4'h0, serialFlag};
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdataNext = 8'h00;
        if (busAddr == `SFRB_ADDR_ENABLE_SYS) begin
            rdataNext = enableSys & `SFRB_MASK_ENABLE_SYS;
        end else if (busAddr == `SFRB_ADDR_ENABLE_SERIAL) begin
            rdataNext = enableSerial & `SFRB_MASK_SERIAL;
        end else if (busAddr == `SFRB_ADDR_FLAGS_SYS) begin
            rdataNext = flagsSys & `SFRB_MASK_FLAGS_SYS;
        end else if (busAddr == `SFRB_ADDR_FLAGS_SERIAL) begin
            rdataNext = flagsSerial & `SFRB_MASK_SERIAL;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busRdata <= 8'h00;
        end else if (busRead) begin
            busRdata <= rdataNext;
        end
    end

    // request outputs, registered; general enable lives outside
    always_ff @(posedge clk) begin
        if (pucClear) begin
            wdogIrq     <= 1'b0;
            nmiIrq      <= 1'b0;
            serialRxIrq <= 1'b0;
            serialTxIrq <= 1'b0;
        end else begin
            wdogIrq     <= wdogFlag && wdog_irq_en_reg
                           && wdogMode == SFRB_WDOG_INTERVAL;
            nmiIrq      <= (oscFaultFlag && osc_fault_irq_en_reg)
                           || (pinEventFlag && pin_event_irq_en_reg)
                           || (flashViolation && flash_violation_irq_en_reg);
            serialRxIrq <= (serialFlag[`SFRB_BIT_A_RX] && serial_irq_en_reg[`SFRB_BIT_A_RX])
                           || (serialFlag[`SFRB_BIT_B_RX] && serial_irq_en_reg[`SFRB_BIT_B_RX]);
            serialTxIrq <= (serialFlag[`SFRB_BIT_A_TX] && serial_irq_en_reg[`SFRB_BIT_A_TX])
                           || (serialFlag[`SFRB_BIT_B_TX] && serial_irq_en_reg[`SFRB_BIT_B_TX]);
        end
    end
endmodule : sfrb_bank

//--- verilog/sfrb_defs.svh
`ifndef SFRB_DEFS_SVH
`define SFRB_DEFS_SVH

// byte addresses of the register bank
`define SFRB_ADDR_ENABLE_SYS    8'h00
`define SFRB_ADDR_ENABLE_SERIAL 8'h01
`define SFRB_ADDR_FLAGS_SYS     8'h02
`define SFRB_ADDR_FLAGS_SERIAL  8'h03

// enable bank, system group
`define SFRB_BIT_WDOG_EN        0
`define SFRB_BIT_OSC_EN         1
`define SFRB_BIT_PIN_EN         4
`define SFRB_BIT_FLASH_EN       5
// flag bank, system group
`define SFRB_BIT_WDOG_FLAG      0
`define SFRB_BIT_OSC_FLAG       1
`define SFRB_BIT_PON_FLAG       2
`define SFRB_BIT_EXT_FLAG       3
`define SFRB_BIT_PIN_FLAG       4
// serial groups, same positions in enable and flag banks
`define SFRB_BIT_A_RX           0
`define SFRB_BIT_A_TX           1
`define SFRB_BIT_B_RX           2
`define SFRB_BIT_B_TX           3

// implemented bit masks
`define SFRB_MASK_ENABLE_SYS    8'h33
`define SFRB_MASK_SERIAL        8'h0F
`define SFRB_MASK_FLAGS_SYS     8'h1F

// reset values
`define SFRB_RST_ENABLE         1'b0
`define SFRB_RST_OSC_FLAG       1'b1
`define SFRB_RST_PIN_FLAG       1'b0
`define SFRB_RST_WDOG_FLAG      1'b0
`define SFRB_RST_EXT_FLAG       1'b0
`define SFRB_RST_PON_FLAG       1'b1
`define SFRB_RST_RX_FLAG        1'b0
`define SFRB_RST_TX_FLAG        1'b1

`endif

//--- verilog/sfrb_pkg.sv
package sfrb_pkg;
    typedef logic [7:0] sfrb_byte_t;
    typedef logic [7:0] sfrb_addr_t;
    typedef enum logic {
        SFRB_WDOG_RESET,
        SFRB_WDOG_INTERVAL
    } sfrb_wdog_mode_t;
endpackage : sfrb_pkg

//--- verilog/sfrb_flag_bit.sv
`timescale 1ns/1ps
// one sticky flag: event set beats software clear in the same cycle
module sfrb_flag_bit #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clk,        // system clock
    input  wire logic clear,      // load reset value, synchronous
    input  wire logic setEvent,   // hardware set pulse
    input  wire logic writeEn,    // software write strobe
    input  wire logic writeData,  // software write value
    output logic      flag        // stored flag
);
    always_ff @(posedge clk) begin
        if (clear) begin
            flag <= RESET_VALUE;
        end else if (setEvent) begin
            flag <= 1'b1;
        end else if (writeEn) begin
            flag <= writeData;
        end
    end
endmodule : sfrb_flag_bit

//--- sim/sfrb_bank_chk.sv
`timescale 1ns/1ps
module sfrb_bank_chk (
    input wire logic                      clk,              // clock
    input wire logic                      rst_n,            // reset
    input wire logic                      powerUpClear,     // clear
    input wire sfrb_pkg::sfrb_addr_t      busAddr,          // address
    input wire logic                      busWrite,         // write
    input wire logic                      busRead,          // read
    input wire sfrb_pkg::sfrb_byte_t      busWdata,         // wdata
    input wire sfrb_pkg::sfrb_byte_t      busRdata,         // rdata
    input wire sfrb_pkg::sfrb_wdog_mode_t wdogMode,         // mode
    input wire logic                      wdogOverflow,     // overflow
    input wire logic                      wdogKeyViolation, // key
    input wire logic                      pinInterruptMode, // pin mode
    input wire logic                      pinEvent,         // pin event
    input wire logic                      pinResetEvent,    // pin reset
    input wire logic                      oscFault,         // fault
    input wire logic                      wdogIrq,          // irq
    input wire logic                      nmiIrq,           // irq
    input wire logic                      serialRxIrq,      // irq
    input wire logic                      serialTxIrq       // irq
);
    import sfrb_pkg::*;
    default clocking cbk @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    reset_vals_a: assert property ($rose(rst_n) |-> busRdata == 8'h00 &&
        !(wdogIrq || nmiIrq || serialRxIrq || serialTxIrq)) else $error("reset values wrong");
    wdog_gate_a: assert property (wdogIrq |-> $past(wdogMode) == SFRB_WDOG_INTERVAL)
        else $error("watchdog irq outside interval mode");
    unmapped_zero_a: assert property (busRead && busAddr > 8'h03 |=> busRdata == 8'h00)
        else $error("unmapped read not zero");
    puc_quiet_a: assert property (powerUpClear |=> ##1 !(nmiIrq || serialRxIrq ||
        serialTxIrq || wdogIrq)) else $error("irq after clear");
    en_readback_a: assert property (busWrite && busAddr == 8'h00 ##1 !busWrite &&
        !powerUpClear ##1 busRead && busAddr == 8'h00 |=> busRdata == ($past(busWdata, 3) & 8'h33))
        else $error("enable readback wrong");
    rdata_hold_a: assert property (!busRead && !powerUpClear |=> $stable(busRdata))
        else $error("read data moved");
    pin_flag_a: assert property (pinEvent && pinInterruptMode && !powerUpClear ##1
        busRead && busAddr == 8'h02 |=> busRdata[4]) else $error("pin flag not set");
    ext_flag_a: assert property (pinResetEvent && !pinInterruptMode && !powerUpClear ##1
        busRead && busAddr == 8'h02 |=> busRdata[3] && !busRdata[0]) else $error("ext flag");
    wdog_flag_a: assert property ((wdogKeyViolation || wdogOverflow &&
        wdogMode == SFRB_WDOG_RESET) && !pinResetEvent ##1 busRead && busAddr == 8'h02
        |=> busRdata[0]) else $error("watchdog flag not set");
    osc_flag_a: assert property (oscFault [*5] ##0 busRead && busAddr == 8'h02
        |=> busRdata[1]) else $error("osc flag not set");
endmodule : sfrb_bank_chk

bind sfrb_bank sfrb_bank_chk chk (.*);

//--- sim/sfrb_cpu_model.sv
`timescale 1ns/1ps
// cpu side of the byte bus; an idle cycle follows each access
module sfrb_cpu_model (
    input  wire logic                 clk,      // system clock
    output sfrb_pkg::sfrb_addr_t      busAddr,  // byte address
    output logic                      busWrite, // write strobe
    output logic                      busRead,  // read strobe
    output sfrb_pkg::sfrb_byte_t      busWdata, // write data
    input  wire sfrb_pkg::sfrb_byte_t busRdata  // read data
);
    import sfrb_pkg::*;
    initial begin
        busAddr = 8'h00;
        busWrite = 1'b0;
        busRead = 1'b0;
        busWdata = 8'h00;
    end
    task automatic wr(input sfrb_addr_t a, input sfrb_byte_t d);
        busAddr = a;
        busWdata = d;
        busWrite = 1'b1;
        @(posedge clk);
        #1;
        busWrite = 1'b0;
        busWdata = ~d; // idle data must not look valid
        @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(input sfrb_addr_t a, output sfrb_byte_t d);
        busAddr = a;
        busRead = 1'b1;
        @(posedge clk);
        #1;
        busRead = 1'b0;
        d = busRdata;
        @(posedge clk);
        #1;
    endtask : rd
endmodule : sfrb_cpu_model

//--- sim/tb_sfr_interrupt_enable_flag_bank.sv
`timescale 1ns/1ps
module tb_sfr_interrupt_enable_flag_bank;
    import sfrb_pkg::*;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            powerUpClear = 1'b0;
    sfrb_addr_t      busAddr;
    logic            busWrite, busRead;
    sfrb_byte_t      busWdata, busRdata, rd;
    sfrb_wdog_mode_t wdogMode = SFRB_WDOG_RESET;
    logic            wdogOverflow = 1'b0, wdogKeyViolation = 1'b0, pinInterruptMode = 1'b0;
    logic            pinEvent = 1'b0, pinResetEvent = 1'b0, oscFault = 1'b0;
    logic            flashViolation = 1'b0, serialARxEvent = 1'b0, serialATxEvent = 1'b0;
    logic            serialBRxEvent = 1'b0, serialBTxEvent = 1'b0;
    logic            wdogIrq, nmiIrq, serialRxIrq, serialTxIrq;
    int              fail_count = 0;
    int              total_checks = 0;
    sfrb_byte_t      rstExp [5] = '{8'h00, 8'h00, 8'h06, 8'h0A, 8'h00};
    sfrb_byte_t      fullExp [5] = '{8'h33, 8'h0F, 8'h1F, 8'h0F, 8'h00};

    sfrb_bank dut (.*);
    sfrb_cpu_model cpu (.*);

    always #2 clk = ~clk;

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input string what, input sfrb_byte_t exp, input sfrb_byte_t got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    initial begin
        repeat (3) tick();
        rst_n = 1'b1;
        for (int a = 0; a < 5; a++) begin
            cpu.rd(8'(a), rd);
            check("reset value", rstExp[a], rd);
        end
        $display("test reset values done");
        for (int a = 0; a < 5; a++) begin
            cpu.wr(8'(a), 8'hFF);
            cpu.rd(8'(a), rd);
            check("write ones", fullExp[a], rd);
        end
        $display("test write ones done");
        powerUpClear = 1'b1;
        tick();
        powerUpClear = 1'b0;
        rstExp[2] = 8'h0F; // power-on bits survive the clear
        for (int a = 0; a < 4; a++) begin
            cpu.rd(8'(a), rd);
            check("after clear", rstExp[a], rd);
        end
        $display("test power-up clear done");
        cpu.wr(8'h02, 8'h00);
        cpu.wr(8'h03, 8'h00);
        pinInterruptMode = 1'b1;
        pinEvent = 1'b1;
        tick();
        pinEvent = 1'b0;
        pinInterruptMode = 1'b0;
        cpu.rd(8'h02, rd);
        check("pin flag", 8'h10, rd);
        wdogOverflow = 1'b1;
        tick();
        wdogOverflow = 1'b0;
        cpu.rd(8'h02, rd);
        check("wdog flag", 8'h11, rd);
        pinResetEvent = 1'b1;
        tick();
        pinResetEvent = 1'b0;
        cpu.rd(8'h02, rd);
        check("ext flag", 8'h18, rd);
        wdogOverflow = 1'b1;
        tick();
        wdogOverflow = 1'b0;
        pinInterruptMode = 1'b1;
        pinResetEvent = 1'b1;
        tick();
        pinResetEvent = 1'b0;
        pinInterruptMode = 1'b0;
        cpu.rd(8'h02, rd);
        check("pin mode reset", 8'h19, rd);
        oscFault = 1'b1;
        repeat (4) tick();
        cpu.rd(8'h02, rd);
        check("osc flag", 8'h1B, rd);
        oscFault = 1'b0;
        {serialBTxEvent, serialBRxEvent, serialATxEvent, serialARxEvent} = 4'hF;
        tick();
        {serialBTxEvent, serialBRxEvent, serialATxEvent, serialARxEvent} = 4'h0;
        cpu.rd(8'h03, rd);
        check("serial flags", 8'h0F, rd);
        $display("test flag events done");
        cpu.wr(8'h01, 8'h01);
        check("serial irqs", 8'h01, {6'h00, serialTxIrq, serialRxIrq});
        cpu.wr(8'h01, 8'h0A);
        check("serial irqs", 8'h02, {6'h00, serialTxIrq, serialRxIrq});
        cpu.wr(8'h02, 8'h00);
        flashViolation = 1'b1;
        repeat (2) tick();
        check("nmi masked", 8'h00, {7'h00, nmiIrq});
        cpu.wr(8'h00, 8'h20);
        check("nmi enabled", 8'h01, {7'h00, nmiIrq});
        flashViolation = 1'b0;
        wdogMode = SFRB_WDOG_INTERVAL;
        cpu.wr(8'h00, 8'h01);
        wdogKeyViolation = 1'b1;
        tick();
        wdogKeyViolation = 1'b0;
        tick();
        check("wdog irq", 8'h01, {7'h00, wdogIrq});
        wdogMode = SFRB_WDOG_RESET;
        repeat (2) tick();
        check("wdog irq", 8'h00, {7'h00, wdogIrq});
        $display("test interrupt gating done");
        summarize();
    end

    initial begin
        #10000;
        fail_count++;
        $display("[ERR] run timed out");
        summarize();
    end
endmodule : tb_sfr_interrupt_enable_flag_bank
